// File: pkg/adc_config_consts.vh
// register map, field positions, reset values and mode codes of the converter configuration
`ifndef ADC_CONFIG_CONSTS_VH
`define ADC_CONFIG_CONSTS_VH

// ----------------------------------------
// register addresses
// ----------------------------------------
`define REG_MODE 6'h01
`define REG_IFACE 6'h02
`define REG_ID 6'h07
`define REG_CH_BASE 6'h10
`define REG_SETUP_BASE 6'h20
`define REG_FILT_BASE 6'h28
`define REG_OFFS_BASE 6'h30
`define REG_GAIN_BASE 6'h38

// ----------------------------------------
// reset values and writable masks
// ----------------------------------------
`define MODE_RST 16'h2000
`define IFACE_RST 16'h0000
`define CH0_RST 24'h008001
`define CH_RST 24'h000001
`define SETUP_RST 24'h001000
`define FILT_RST 24'h000000
`define OFFS_RST 24'h800000
`define SETUP_CFG_RST 16'h1000
`define FILT_CFG_RST 16'h0000
`define CH_ENABLE_RST 16'h0001
`define MODE_MASK 24'h00a77c
`define IFACE_MASK 24'h0000ed
`define CH_MASK 24'h00f3ff
`define SETUP_MASK 24'h001ff0
`define FILT_MASK 24'h008f7f
`define COEFF_MASK 24'hffffff

// ----------------------------------------
// field positions
// ----------------------------------------
`define CH_EN_BIT 15
`define CH_SETUP_HI 14
`define CH_SETUP_LO 12
`define CH_POS_HI 9
`define CH_POS_LO 5
`define CH_NEG_HI 4
`define CH_NEG_LO 0
`define MODE_REF_EN_BIT 15
`define MODE_SING_BIT 13
`define MODE_DELAY_HI 10
`define MODE_DELAY_LO 8
`define MODE_FIELD_HI 6
`define MODE_FIELD_LO 4
`define MODE_CLK_HI 3
`define MODE_CLK_LO 2
`define IFACE_CONTREAD_BIT 7
`define IFACE_STATUS_BIT 6
`define IFACE_CRC_HI 3
`define IFACE_CRC_LO 2
`define CMD_WEN_BIT 7
`define CMD_READ_BIT 6

// ----------------------------------------
// conversion mode codes and serial constants
// ----------------------------------------
`define CONV_CONT 3'h0
`define CONV_SINGLE 3'h1
`define CONV_STANDBY 3'h2
`define CONV_POWERDOWN 3'h3
`define CONV_INT_ZERO 3'h4
`define CONV_SYS_ZERO 3'h6
`define CONV_SYS_FULL 3'h7
`define RESET_ONES 7'd64
`define BITS_SHORT 5'd16
`define BITS_LONG 5'd24

`endif

// File: hw/setup_store.v
// storage of channel, setup, filter, offset and gain words with registered read ports
`timescale 1ns/1ps
module setup_store #(
    parameter DEPTH = 48,
    parameter WIDTH = 24,
    parameter [23:0] GAIN_FACTORY = 24'h500000
) (
    input wire clock,
    input wire rstn,
    input wire soft_clear,
    input wire we,
    input wire [5:0] wr_idx,
    input wire [WIDTH-1:0] wr_data,
    input wire [5:0] rd_a_idx,
    output reg [WIDTH-1:0] rd_a_data,
    input wire [5:0] rd_b_idx,
    output reg [WIDTH-1:0] rd_b_data
);
`include "adc_config_consts.vh"

    reg [WIDTH-1:0] mem [0:DEPTH-1];
    integer i;

    // ----------------------------------------
    // power-on contents by region
    // ----------------------------------------
    function [23:0] init_val;
        input integer idx;
        begin
            if (idx == 0)
                init_val = `CH0_RST;
            else if (idx < 16)
                init_val = `CH_RST;
            else if (idx < 24)
                init_val = `SETUP_RST;
            else if (idx < 32)
                init_val = `FILT_RST;
            else if (idx < 40)
                init_val = `OFFS_RST;
            else
                init_val = GAIN_FACTORY;
        end
    endfunction

    // soft_clear restores the same contents as the pin reset
    always @(posedge clock or negedge rstn)
    begin
        if (!rstn)
        begin
            for (i = 0; i < DEPTH; i = i + 1)
                mem[i] <= init_val(i);
            rd_a_data <= {WIDTH{1'b0}};
            rd_b_data <= {WIDTH{1'b0}};
        end
        else if (soft_clear)
        begin
            for (i = 0; i < DEPTH; i = i + 1)
                mem[i] <= init_val(i);
            rd_a_data <= {WIDTH{1'b0}};
            rd_b_data <= {WIDTH{1'b0}};
        end
        else
        begin
            if (we)
                mem[wr_idx] <= wr_data;
            rd_a_data <= mem[rd_a_idx];
            rd_b_data <= mem[rd_b_idx];
        end
    end
endmodule

// File: hw/adc_config_core.v
// serial register access, channel sequencer and active setup selection of the converter
`timescale 1ns/1ps
module adc_config_core #(
    parameter [23:0] GAIN_FACTORY = 24'h500000,
    // arbitrary identification value
    parameter [15:0] DEVICE_ID = 16'h4a50
) (
    input wire clock,
    input wire rstn,
    input wire sclk,
    input wire cs_n,
    input wire din,
    input wire conversion_done,
    input wire [23:0] calibration_result,
    output reg dout,
    output reg dout_oe_n,
    output reg [3:0] active_channel,
    output reg [2:0] active_setup,
    output reg [4:0] positive_input_code,
    output reg [4:0] negative_input_code,
    output reg [15:0] active_setup_config,
    output reg [15:0] active_filter,
    output reg [23:0] active_offset,
    output reg [23:0] active_gain,
    output reg [15:0] converter_mode_control,
    output reg [15:0] serial_interface_control
);
`include "adc_config_consts.vh"

    localparam [2:0] ST_CMD = 3'b001;
    localparam [2:0] ST_WR = 3'b010;
    localparam [2:0] ST_RD = 3'b100;

    reg sclk_q_r;
    reg [6:0] ones_cnt_r;
    reg [2:0] state_r;
    reg [23:0] sh_in_r;
    reg [4:0] bit_cnt_r;
    reg [5:0] addr_r;
    reg [4:0] len_r;
    reg [1:0] load_r;
    reg [23:0] out_sr_r;
    reg [15:0] ch_en_r;
    reg [3:0] chan_r;
    reg [2:0] step_r;
    reg cal_pend_r;
    reg cal_gain_r;
    reg [2:0] cal_setup_r;
    reg [23:0] cal_val_r;

    wire sclk_rise;
    wire sclk_fall;
    wire full_reset;
    wire [7:0] cmd_byte;
    wire [23:0] in_word;
    wire last_bit;
    wire spi_we;
    wire spi_mem_we;
    wire cal_we;
    wire [2:0] mode_field;
    wire [23:0] rd_a_data;
    wire [23:0] rd_b_data;
    wire [23:0] wr_word;
    reg [5:0] rd_b_idx;
    reg [23:0] rd_word;

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    function [4:0] reg_bits;
        input [5:0] addr;
        begin
            reg_bits = (addr >= `REG_OFFS_BASE) ? `BITS_LONG : `BITS_SHORT;
        end
    endfunction

    function [23:0] reg_mask;
        input [5:0] addr;
        begin
            if (addr >= `REG_OFFS_BASE)
                reg_mask = `COEFF_MASK;
            else if (addr >= `REG_FILT_BASE)
                reg_mask = `FILT_MASK;
            else if (addr >= `REG_SETUP_BASE)
                reg_mask = `SETUP_MASK;
            else if (addr >= `REG_CH_BASE)
                reg_mask = `CH_MASK;
            else if (addr == `REG_MODE)
                reg_mask = `MODE_MASK;
            else if (addr == `REG_IFACE)
                reg_mask = `IFACE_MASK;
            else
                reg_mask = 24'h000000;
        end
    endfunction

    function [5:0] mem_idx;
        input [5:0] addr;
        begin
            mem_idx = addr - `REG_CH_BASE;
        end
    endfunction

    // next enabled channel above cur, wrapping; stays put when none is enabled
    function [3:0] next_chan;
        input [15:0] en;
        input [3:0] cur;
        integer k;
        reg [3:0] cand;
        reg found;
        begin
            next_chan = cur;
            found = 1'b0;
            cand = cur;
            for (k = 1; k <= 16; k = k + 1)
            begin
                cand = cur + k[3:0];
                if (!found && en[cand])
                begin
                    next_chan = cand;
                    found = 1'b1;
                end
            end
        end
    endfunction

    // ----------------------------------------
    // serial edge detection
    // ----------------------------------------
    // rising samples, falling drives
    assign sclk_rise = sclk & ~sclk_q_r;
    assign sclk_fall = ~sclk & sclk_q_r;
    assign full_reset = sclk_rise & ~cs_n & din & (ones_cnt_r == `RESET_ONES - 7'd1);

    assign cmd_byte = {sh_in_r[6:0], din};
    assign in_word = {sh_in_r[22:0], din};
    assign last_bit = (bit_cnt_r == len_r - 5'd1);
    assign spi_we = (state_r == ST_WR) & sclk_rise & ~cs_n & last_bit & ~full_reset;
    assign spi_mem_we = spi_we & (addr_r >= `REG_CH_BASE);
    assign cal_we = cal_pend_r & ~spi_mem_we;
    assign wr_word = in_word & reg_mask(addr_r);
    assign mode_field = converter_mode_control[`MODE_FIELD_HI:`MODE_FIELD_LO];

    always @(posedge clock or negedge rstn)
    begin
        if (!rstn)
        begin
            sclk_q_r <= 1'b1;
            ones_cnt_r <= 7'd0;
        end
        else
        begin
            sclk_q_r <= sclk;
            if (full_reset || cs_n)
                ones_cnt_r <= 7'd0;
            else if (sclk_rise)
                ones_cnt_r <= din ? ones_cnt_r + 7'd1 : 7'd0;
        end
    end

    // ----------------------------------------
    // command and data shifting
    // ----------------------------------------
    always @*
    begin
        if (addr_r >= `REG_CH_BASE)
            rd_word = rd_a_data;
        else if (addr_r == `REG_MODE)
            rd_word = {8'h00, converter_mode_control};
        else if (addr_r == `REG_IFACE)
            rd_word = {8'h00, serial_interface_control};
        else if (addr_r == `REG_ID)
            rd_word = {8'h00, DEVICE_ID};
        else
            rd_word = 24'h000000;
    end

    always @(posedge clock or negedge rstn)
    begin
        if (!rstn)
        begin
            state_r <= ST_CMD;
            sh_in_r <= 24'h000000;
            bit_cnt_r <= 5'd0;
            addr_r <= 6'h00;
            len_r <= `BITS_SHORT;
            load_r <= 2'b00;
            out_sr_r <= 24'h000000;
            dout <= 1'b1;
            dout_oe_n <= 1'b1;
        end
        else if (full_reset || cs_n)
        begin
            // deselect aborts the access; the command byte is awaited again
            state_r <= ST_CMD;
            bit_cnt_r <= 5'd0;
            load_r <= 2'b00;
            dout <= 1'b1;
            dout_oe_n <= 1'b1;
        end
        else
        begin
            load_r <= {load_r[0], 1'b0};
            dout_oe_n <= (state_r != ST_RD);
            if (load_r[1])
                out_sr_r <= rd_word << (5'd24 - len_r);
            if (sclk_rise)
                sh_in_r <= in_word;
            case (state_r)
                ST_CMD:
                begin
                    if (sclk_rise)
                    begin
                        bit_cnt_r <= bit_cnt_r + 5'd1;
                        if (bit_cnt_r == 5'd7)
                        begin
                            bit_cnt_r <= 5'd0;
                            if (!cmd_byte[`CMD_WEN_BIT])
                            begin
                                addr_r <= cmd_byte[5:0];
                                len_r <= reg_bits(cmd_byte[5:0]);
                                state_r <= cmd_byte[`CMD_READ_BIT] ? ST_RD : ST_WR;
                                load_r <= {1'b0, cmd_byte[`CMD_READ_BIT]};
                            end
                        end
                    end
                end
                ST_WR:
                begin
                    if (sclk_rise)
                    begin
                        bit_cnt_r <= last_bit ? 5'd0 : bit_cnt_r + 5'd1;
                        if (last_bit)
                            state_r <= ST_CMD;
                    end
                end
                ST_RD:
                begin
                    if (sclk_fall)
                    begin
                        dout <= out_sr_r[23];
                        out_sr_r <= {out_sr_r[22:0], 1'b0};
                    end
                    if (sclk_rise)
                    begin
                        bit_cnt_r <= last_bit ? 5'd0 : bit_cnt_r + 5'd1;
                        if (last_bit)
                            state_r <= ST_CMD;
                    end
                end
                default:
                    state_r <= ST_CMD;
            endcase
        end
    end

    // ----------------------------------------
    // mode, interface and calibration control
    // ----------------------------------------
    always @(posedge clock or negedge rstn)
    begin
        if (!rstn)
        begin
            converter_mode_control <= `MODE_RST;
            serial_interface_control <= `IFACE_RST;
            ch_en_r <= `CH_ENABLE_RST;
            chan_r <= 4'd0;
            cal_pend_r <= 1'b0;
            cal_gain_r <= 1'b0;
            cal_setup_r <= 3'd0;
            cal_val_r <= 24'h000000;
        end
        else if (full_reset)
        begin
            converter_mode_control <= `MODE_RST;
            serial_interface_control <= `IFACE_RST;
            ch_en_r <= `CH_ENABLE_RST;
            chan_r <= 4'd0;
            cal_pend_r <= 1'b0;
        end
        else
        begin
            if (cal_we)
                cal_pend_r <= 1'b0;
            if (conversion_done)
            begin
                if (mode_field == `CONV_CONT)
                    chan_r <= next_chan(ch_en_r, chan_r);
                if (mode_field == `CONV_INT_ZERO || mode_field == `CONV_SYS_ZERO ||
                    mode_field == `CONV_SYS_FULL)
                begin
                    cal_pend_r <= 1'b1;
                    cal_gain_r <= (mode_field == `CONV_SYS_FULL);
                    cal_setup_r <= active_setup;
                    cal_val_r <= calibration_result;
                end
                // single and calibration fall back to standby
                if (mode_field == `CONV_SINGLE || mode_field[2])
                    converter_mode_control[`MODE_FIELD_HI:`MODE_FIELD_LO] <= `CONV_STANDBY;
            end
            // mode register takes the written word with its non-writable bits cleared
            if (spi_we && addr_r == `REG_MODE)
                converter_mode_control <= wr_word[15:0];
            if (spi_we && addr_r == `REG_IFACE)
                serial_interface_control <= wr_word[15:0];
            // enable bit mirrored for the sequencer
            if (spi_mem_we && addr_r < `REG_SETUP_BASE)
                ch_en_r[addr_r[3:0]] <= wr_word[`CH_EN_BIT];
        end
    end

    // ----------------------------------------
    // active setup fetch loop
    // ----------------------------------------
    // settings follow the channel's setup index
    always @*
    begin
        case (step_r)
            3'd0: rd_b_idx = {2'b00, chan_r};
            3'd1: rd_b_idx = mem_idx(`REG_SETUP_BASE) + {3'b000, rd_b_data[`CH_SETUP_HI:`CH_SETUP_LO]};
            3'd2: rd_b_idx = mem_idx(`REG_FILT_BASE) + {3'b000, active_setup};
            3'd3: rd_b_idx = mem_idx(`REG_OFFS_BASE) + {3'b000, active_setup};
            3'd4: rd_b_idx = mem_idx(`REG_GAIN_BASE) + {3'b000, active_setup};
            default: rd_b_idx = 6'h00;
        endcase
    end

    always @(posedge clock or negedge rstn)
    begin
        if (!rstn)
        begin
            step_r <= 3'd0;
            // channel 0, inputs 0 and 1, setup 0
            active_channel <= 4'd0;
            active_setup <= 3'd0;
            positive_input_code <= 5'd0;
            negative_input_code <= 5'd1;
            active_setup_config <= `SETUP_CFG_RST;
            active_filter <= `FILT_CFG_RST;
            active_offset <= `OFFS_RST;
            active_gain <= GAIN_FACTORY;
        end
        else
        begin
            step_r <= (step_r == 3'd4) ? 3'd0 : step_r + 3'd1;
            case (step_r)
                3'd1:
                begin
                    active_channel <= chan_r;
                    active_setup <= rd_b_data[`CH_SETUP_HI:`CH_SETUP_LO];
                    positive_input_code <= rd_b_data[`CH_POS_HI:`CH_POS_LO];
                    negative_input_code <= rd_b_data[`CH_NEG_HI:`CH_NEG_LO];
                end
                3'd2: active_setup_config <= rd_b_data[15:0];
                3'd3: active_filter <= rd_b_data[15:0];
                3'd4: active_offset <= rd_b_data;
                3'd0: active_gain <= rd_b_data;
                default: step_r <= 3'd0;
            endcase
        end
    end

    // ----------------------------------------
    // channel and setup storage
    // ----------------------------------------
    // sixteen channels, eight setups in one store
    setup_store #(
        .DEPTH(48),
        .WIDTH(24),
        .GAIN_FACTORY(GAIN_FACTORY)
    ) store (
        .clock(clock),
        .rstn(rstn),
        .soft_clear(full_reset),
        .we(spi_mem_we | cal_we),
        .wr_idx(spi_mem_we ? mem_idx(addr_r) :
            ((cal_gain_r ? mem_idx(`REG_GAIN_BASE) : mem_idx(`REG_OFFS_BASE)) +
            {3'b000, cal_setup_r})),
        .wr_data(spi_mem_we ? wr_word : cal_val_r),
        .rd_a_idx(mem_idx(addr_r)),
        .rd_a_data(rd_a_data),
        .rd_b_idx(rd_b_idx),
        .rd_b_data(rd_b_data)
    );
endmodule

// File: test/adc_config_asserts.sv
// concurrent checks on the converter configuration ports
`timescale 1ns/1ps
module adc_config_asserts (
    input wire clock,
    input wire rstn,
    input wire sclk,
    input wire cs_n,
    input wire conversion_done,
    input wire [23:0] calibration_result,
    input wire dout,
    input wire dout_oe_n,
    input wire [3:0] active_channel,
    input wire [2:0] active_setup,
    input wire [4:0] positive_input_code,
    input wire [4:0] negative_input_code,
    input wire [15:0] active_setup_config,
    input wire [23:0] active_offset,
    input wire [23:0] active_gain,
    input wire [15:0] converter_mode_control,
    input wire [15:0] serial_interface_control
);
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rstn);
    wire [2:0] mfield = converter_mode_control[6:4];
    // host silent long enough that no write can land
    sequence s_quiet;
        cs_n [*3];
    endsequence
    sequence s_drive_step;
        !dout_oe_n ##1 (!dout_oe_n && $changed(dout));
    endsequence
    property p_rst_chan;
        $rose(rstn) |-> active_channel == 4'h0 && active_setup == 3'h0
            && positive_input_code == 5'h00 && negative_input_code == 5'h01;
    endproperty
    a_rst_chan: assert property (p_rst_chan) else $error("channel state after reset");
    property p_rst_setup;
        $rose(rstn) |-> active_setup_config == 16'h1000 && active_offset == 24'h800000;
    endproperty
    a_rst_setup: assert property (p_rst_setup) else $error("setup after reset");
    property p_rst_mode;
        $rose(rstn) |-> converter_mode_control == 16'h2000;
    endproperty
    a_rst_mode: assert property (p_rst_mode) else $error("mode after reset");
    property p_rst_iface;
        $rose(rstn) |-> serial_interface_control == 16'h0000;
    endproperty
    a_rst_iface: assert property (p_rst_iface) else $error("interface after reset");
    property p_oe_cs;
        !dout_oe_n |-> !$past(cs_n);
    endproperty
    a_oe_cs: assert property (p_oe_cs) else $error("output driven while deselected");
    property p_dout_fall;
        s_drive_step |-> !$past(sclk);
    endproperty
    a_dout_fall: assert property (p_dout_fall) else $error("output moved off drive edge");
    property p_chan_step;
        active_channel != $past(active_channel)
            |-> $past(conversion_done) || $past(conversion_done, 2) || $past(conversion_done, 3)
            || $past(conversion_done, 4) || $past(conversion_done, 5)
            || $past(conversion_done, 6) || active_channel == 4'h0;
    endproperty
    a_chan_step: assert property (p_chan_step) else $error("channel moved unprompted");
    property p_single_stop;
        s_quiet ##0 (conversion_done && (mfield == 3'h1 || mfield[2]))
            |=> mfield == 3'h2;
    endproperty
    a_single_stop: assert property (p_single_stop) else $error("no standby");
    property p_cal_offset;
        s_quiet ##0 (conversion_done && (mfield == 3'h4 || mfield == 3'h6))
            |-> ##[1:16] active_offset == calibration_result;
    endproperty
    a_cal_offset: assert property (p_cal_offset) else $error("offset not loaded");
    property p_cal_gain;
        s_quiet ##0 (conversion_done && mfield == 3'h7)
            |-> ##[1:16] active_gain == calibration_result;
    endproperty
    a_cal_gain: assert property (p_cal_gain) else $error("gain not loaded");
    property p_mode_hold;
        s_quiet ##0 !conversion_done |=> $stable(converter_mode_control);
    endproperty
    a_mode_hold: assert property (p_mode_hold) else $error("mode changed unprompted");
endmodule

bind adc_config_core adc_config_asserts i_asserts (
    .clock(clock), .rstn(rstn), .sclk(sclk), .cs_n(cs_n),
    .conversion_done(conversion_done), .calibration_result(calibration_result),
    .dout(dout), .dout_oe_n(dout_oe_n), .active_channel(active_channel),
    .active_setup(active_setup), .positive_input_code(positive_input_code),
    .negative_input_code(negative_input_code), .active_setup_config(active_setup_config),
    .active_offset(active_offset), .active_gain(active_gain),
    .converter_mode_control(converter_mode_control),
    .serial_interface_control(serial_interface_control)
);

// File: test/spi_host.sv
// serial host model driving the register link
`timescale 1ns/1ps
module spi_host (
    input wire clock,
    input wire dout,
    input wire dout_oe_n,
    output logic sclk,
    output logic cs_n,
    output logic din
);
    initial
    begin
        sclk = 1'b1;
        cs_n = 1'b1;
        din = 1'b0;
    end
    // drive on fall, sample on rise
    task automatic bit_io(input logic b, output logic q);
        repeat (4) @(negedge clock);
        sclk = 1'b0;
        din = b;
        repeat (4) @(negedge clock);
        sclk = 1'b1;
        // an undriven line reads as the inverse
        q = dout_oe_n ? ~dout : dout;
    endtask
    task automatic frame(input int n, input logic [63:0] w, output logic [63:0] q);
        logic b;
        @(negedge clock);
        cs_n = 1'b0;
        q = '0;
        for (int i = n - 1; i >= 0; i--)
        begin
            bit_io(w[i], b);
            q[i] = b;
        end
        repeat (4) @(negedge clock);
        cs_n = 1'b1;
        // released line must not look like the last bit
        din = ~din;
        repeat (4) @(negedge clock);
    endtask
    task automatic access(input logic rd, input logic [5:0] a, input logic [23:0] w,
        output logic [23:0] r);
        int n;
        logic [63:0] q;
        n = (a >= 6'h30) ? 24 : 16;
        frame(n + 8, ({56'h0, 1'b0, rd, a} << n) | {40'h0, w}, q);
        r = (n == 24) ? q[23:0] : {8'h0, q[15:0]};
    endtask
    // long run of ones resets all
    task automatic sreset();
        logic [63:0] q;
        frame(64, {64{1'b1}}, q);
    endtask
endmodule

// File: test/tb_top.sv
// self-checking bench for the converter configuration block
`timescale 1ns/1ps
module tb_top;
    localparam logic [23:0] GAIN_INIT = 24'h5abcd0;
    // arbitrary identification value
    localparam logic [15:0] ID_VAL = 16'h1b2c;
    logic clock = 1'b0;
    logic rstn = 1'b0;
    logic conversion_done = 1'b0;
    logic [23:0] calibration_result = 24'h0;
    wire sclk, cs_n, din, dout, dout_oe_n;
    wire [3:0] active_channel;
    wire [2:0] active_setup;
    wire [4:0] positive_input_code;
    wire [4:0] negative_input_code;
    wire [15:0] active_filter;
    wire [15:0] active_setup_config;
    int err_count = 0;
    int n_tests = 0;
    int cycles = 0;

    adc_config_core #(.GAIN_FACTORY(GAIN_INIT), .DEVICE_ID(ID_VAL)) i_dut (
        .clock(clock), .rstn(rstn), .sclk(sclk), .cs_n(cs_n), .din(din),
        .conversion_done(conversion_done), .calibration_result(calibration_result),
        .dout(dout), .dout_oe_n(dout_oe_n), .active_channel(active_channel),
        .active_setup(active_setup), .positive_input_code(positive_input_code),
        .negative_input_code(negative_input_code), .active_setup_config(active_setup_config),
        .active_filter(active_filter), .active_offset(), .active_gain(),
        .converter_mode_control(), .serial_interface_control()
    );
    spi_host i_host (.clock(clock), .dout(dout), .dout_oe_n(dout_oe_n), .sclk(sclk),
        .cs_n(cs_n), .din(din));

    initial
    begin
        forever #10 clock = ~clock;
    end
    // -------------------------
    // helper tasks
    // -------------------------
    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
        n_tests++;
        if (got !== exp)
        begin
            err_count++;
            $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask
    task automatic wr(input logic [5:0] a, input logic [23:0] w);
        logic [23:0] q;
        i_host.access(1'b0, a, w, q);
    endtask
    task automatic rd_chk(input logic [5:0] a, input logic [23:0] exp);
        logic [23:0] q;
        i_host.access(1'b1, a, 24'h0, q);
        check({8'h0, q}, {8'h0, exp}, "register read");
    endtask
    // settle time covers the active setup refresh lag
    task automatic pulse();
        @(negedge clock);
        conversion_done = 1'b1;
        @(negedge clock);
        conversion_done = 1'b0;
        repeat (16) @(negedge clock);
    endtask
    task automatic wrap_up();
        $display("tests %0d mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    always @(posedge clock)
    begin
        cycles <= cycles + 1;
        if (cycles == 80000)
        begin
            err_count++;
            wrap_up();
        end
    end
    // -------------------------
    // test sequence
    // -------------------------
    initial
    begin
        logic [5:0] wa [10] = '{6'h11, 6'h13, 6'h1f, 6'h23, 6'h2f, 6'h35, 6'h3f, 6'h01, 6'h05,
            6'h02};
        logic [23:0] wv [10] = '{24'hffff, 24'hb0a6, 24'hf210, 24'hffff, 24'hffff,
            24'h123456, 24'hfedcba, 24'hffff, 24'hffff, 24'hffff};
        logic [23:0] ev [10] = '{24'hf3ff, 24'hb0a6, 24'hf210, 24'h1ff0, 24'h8f7f,
            24'h123456, 24'hfedcba, 24'ha77c, 24'h0, 24'h00ed};
        logic [31:0] se [4] = '{{8'h01, 3'h7, 5'h1f, 16'h1000}, {8'h03, 3'h3, 5'h05, 16'h1ff0},
            {8'h0f, 3'h7, 5'h10, 16'h1000}, {8'h00, 3'h0, 5'h00, 16'h1000}};
        logic [20:0] nf [4] = '{{5'h1f, 16'h8f7f}, {5'h06, 16'h0000}, {5'h10, 16'h8f7f},
            {5'h01, 16'h0000}};
        logic [2:0] cm [3] = '{3'h4, 3'h6, 3'h7};
        logic [5:0] ca [3] = '{6'h30, 6'h30, 6'h38};
        repeat (8) @(negedge clock);
        rstn = 1'b1;
        repeat (2) @(negedge clock);
        rd_chk(6'h01, 24'h002000);
        rd_chk(6'h02, 24'h000000);
        rd_chk(6'h10, 24'h008001);
        rd_chk(6'h1f, 24'h000001);
        rd_chk(6'h27, 24'h001000);
        rd_chk(6'h28, 24'h000000);
        rd_chk(6'h36, 24'h800000);
        rd_chk(6'h38, GAIN_INIT);
        rd_chk(6'h07, {8'h0, ID_VAL});
        $display("test reset values done");
        for (int i = 0; i < 10; i++)
        begin
            wr(wa[i], wv[i]);
            rd_chk(wa[i], ev[i]);
        end
        $display("test register access done");
        wr(6'h01, 24'h002000);
        for (int i = 0; i < 4; i++)
        begin
            pulse();
            check({4'h0, active_channel, active_setup, positive_input_code,
                active_setup_config}, se[i], "sequencer step");
            check({11'h0, negative_input_code, active_filter}, {11'h0, nf[i]},
                "inputs and filter");
        end
        $display("test sequencer done");
        for (int m = 0; m < 8; m++)
        begin
            wr(6'h01, {8'h0, 8'h20, 1'b0, m[2:0], 4'h0});
            rd_chk(6'h01, {8'h0, 8'h20, 1'b0, m[2:0], 4'h0});
        end
        wr(6'h01, 24'h002010);
        pulse();
        rd_chk(6'h01, 24'h002020);
        for (int k = 0; k < 3; k++)
        begin
            calibration_result = 24'h0a0b00 + 24'(k);
            wr(6'h01, {8'h0, 8'h20, 1'b0, cm[k], 4'h0});
            pulse();
            rd_chk(ca[k], 24'h0a0b00 + 24'(k));
            rd_chk(6'h01, 24'h002020);
        end
        $display("test conversion modes done");
        i_host.sreset();
        rd_chk(6'h01, 24'h002000);
        rd_chk(6'h02, 24'h000000);
        rd_chk(6'h13, 24'h000001);
        rd_chk(6'h30, 24'h800000);
        $display("test serial reset done");
        wrap_up();
    end
endmodule
